//--- hdl/rtc_time_date_defines.svh
// Offsets, field positions, reset values and timing counts of the time and date registers
`ifndef RTC_TIME_DATE_DEFINES_SVH
`define RTC_TIME_DATE_DEFINES_SVH

`define RTC_ADDR_W          4
`define RTC_OFS_TIME        4'h0
`define RTC_OFS_DATE        4'h4
`define RTC_OFS_CTRL        4'h8

`define RTC_CTRL_WREN_BIT   3

`define RTC_TIME_RESET      32'h0000_0000
`define RTC_DATE_RESET      32'h0001_0100
`define RTC_TIME_MASK       32'h3F7F_7F00
`define RTC_DATE_MASK       32'hFF1F_3F07

`define RTC_CLK_HZ          250000000
`define RTC_TICK_PERIOD_S   1
`define RTC_TICK_CYCLES     (`RTC_CLK_HZ * `RTC_TICK_PERIOD_S)

`endif

//--- hdl/rtc_time_date_pkg.sv
// Types shared by the time and date register block
`include "rtc_time_date_defines.svh"

package rtc_time_date_pkg;

	typedef struct packed {
		logic [1:0] reserved31;
		logic [1:0] hoursTensDigit;
		logic [3:0] hoursUnitsDigit;
		logic       reserved23;
		logic [2:0] minutesTensDigit;
		logic [3:0] minutesUnitsDigit;
		logic       reserved15;
		logic [2:0] secondsTensDigit;
		logic [3:0] secondsUnitsDigit;
		logic [7:0] reserved7;
	} time_value_s;

	typedef struct packed {
		logic [3:0] yearsTensDigit;
		logic [3:0] yearsUnitsDigit;
		logic [2:0] reserved23;
		logic       monthsTensDigit;
		logic [3:0] monthsUnitsDigit;
		logic [1:0] reserved15;
		logic [1:0] domTensDigit;
		logic [3:0] domUnitsDigit;
		logic [4:0] reserved7;
		logic [2:0] weekdayDigit;
	} date_value_s;

	typedef struct packed {
		logic [`RTC_ADDR_W-1:0] addr;
		logic [31:0]            wdata;
		logic                   wr;
		logic                   rd;
	} reg_req_s;

endpackage

//--- hdl/rtc_time_date_registers.sv
// Time and date holding registers with BCD calendar counter
// Functional notes
// [R01] Hours: tens digit bits 29-28 (0-2), units bits 27-24 (0-9).
// [R02] Minutes: tens digit bits 22-20 (0-5), units bits 19-16 (0-9).
// [R03] Seconds: tens digit bits 14-12 (0-5), units bits 11-8 (0-9).
// [R04] Year: tens bits 31-28, units bits 27-24, each 0-9.
// [R05] Month: tens bit 20 (0 or 1), units bits 19-16.
// [R06] Day of month: tens bits 13-12 (0-3), units bits 11-8.
// [R07] Weekday in date bits 2-0, values 0 through 6.
// [R08] Time and date writes accepted only while control bit 3 is set.
// [R09] Unused time and date bit positions always read zero.
// [R10] Seconds advance once per second with BCD carries through the calendar.
`timescale 1ns/100ps
`include "rtc_time_date_defines.svh"

module rtc_time_date_registers #(
	parameter int unsigned TICK_CYCLES = `RTC_TICK_CYCLES
) (
	input  wire logic                           clk_sys,
	input  wire logic                           reset_n,
	input  wire logic                           clkEn,
	input  wire rtc_time_date_pkg::reg_req_s    regReq,
	output      logic [31:0]                    regRdata,
	output      logic                           clockWriteEnable
);
	import rtc_time_date_pkg::*;

	logic                rstMeta;
	logic                rstSync;
	logic [31:0]         timeReg;
	logic [31:0]         dateReg;
	logic                wrenReg;
	logic [31:0]         tickCnt;
	logic                tickPulse;
	time_value_s         curTime;
	date_value_s         curDate;
	time_value_s         incTime;
	date_value_s         incDate;
	logic [31:0]         next_time;
	logic [31:0]         next_date;
	logic [31:0]         next_rdata;
	logic [4:0]          monthNum;
	logic [5:0]          dayNum;
	logic [5:0]          lastDay;
	logic [6:0]          yearNum;

	wire  hitTime  = (regReq.addr == `RTC_OFS_TIME);
	wire  hitDate  = (regReq.addr == `RTC_OFS_DATE);
	wire  hitCtrl  = (regReq.addr == `RTC_OFS_CTRL);
	wire  wrTime   = regReq.wr && hitTime && wrenReg; // R08
	wire  wrDate   = regReq.wr && hitDate && wrenReg; // R08
	wire  wrCtrl   = regReq.wr && hitCtrl;
	wire  dayCarry = tickPulse && incTime == 32'h0;
	wire [31:0] ctrlRead = {28'h0, wrenReg, 3'h0};
	wire  hoursOk  = (curTime.hoursTensDigit < 2'h2 && curTime.hoursUnitsDigit <= 4'h9) ||
		(curTime.hoursTensDigit == 2'h2 && curTime.hoursUnitsDigit <= 4'h3);
	wire  minutesOk = curTime.minutesTensDigit <= 3'h5 && curTime.minutesUnitsDigit <= 4'h9;
	wire  secondsOk = curTime.secondsTensDigit <= 3'h5 && curTime.secondsUnitsDigit <= 4'h9;
	wire  dayOk    = dayNum != 6'h0 && dayNum <= lastDay && curDate.domUnitsDigit <= 4'h9;
	wire  monthOk  = monthNum != 5'h0 && monthNum <= 5'h0C && curDate.monthsUnitsDigit <= 4'h9;
	wire  yearOk   = curDate.yearsTensDigit <= 4'h9 && curDate.yearsUnitsDigit <= 4'h9;
	wire  weekdayOk = curDate.weekdayDigit <= 3'h6;
	wire  dateOk   = dayOk && monthOk && yearOk && weekdayOk;

	// Reset release through two flip-flops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// One-second timebase
	assign tickPulse = (tickCnt == TICK_CYCLES - 1);

	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			tickCnt <= 32'h0;
		end else if (clkEn) begin
			tickCnt <= tickPulse ? 32'h0 : tickCnt + 32'h1; // R10
		end
	end

	assign curTime = time_value_s'(timeReg);
	assign curDate = date_value_s'(dateReg);
	assign monthNum = 5'(curDate.monthsTensDigit * 5'hA) + 5'(curDate.monthsUnitsDigit);
	assign dayNum = 6'(curDate.domTensDigit * 6'hA) + 6'(curDate.domUnitsDigit);
	assign yearNum = 7'(curDate.yearsTensDigit * 7'hA) + 7'(curDate.yearsUnitsDigit);

	// Month length with leap years on a multiple of four
	always_comb begin
		unique case (monthNum)
			5'h02:   lastDay = (yearNum[1:0] == 2'h0) ? 6'h1D : 6'h1C;
			5'h04,
			5'h06,
			5'h09,
			5'h0B:   lastDay = 6'h1E;
			default: lastDay = 6'h1F;
		endcase
	end

	// BCD time increment; all digits zero marks a day rollover
	always_comb begin
		incTime = curTime;
		incTime.reserved31 = 2'h0;
		incTime.reserved23 = 1'b0;
		incTime.reserved15 = 1'b0;
		incTime.reserved7 = 8'h0;
		if (curTime.secondsUnitsDigit != 4'h9) begin
			incTime.secondsUnitsDigit = curTime.secondsUnitsDigit + 4'h1; // R03
		end else begin
			incTime.secondsUnitsDigit = 4'h0;
			if (curTime.secondsTensDigit != 3'h5) begin
				incTime.secondsTensDigit = curTime.secondsTensDigit + 3'h1; // R03
			end else begin
				incTime.secondsTensDigit = 3'h0;
				if (curTime.minutesUnitsDigit != 4'h9) begin
					incTime.minutesUnitsDigit = curTime.minutesUnitsDigit + 4'h1; // R02
				end else begin
					incTime.minutesUnitsDigit = 4'h0;
					if (curTime.minutesTensDigit != 3'h5) begin
						incTime.minutesTensDigit = curTime.minutesTensDigit + 3'h1; // R02
					end else begin
						incTime.minutesTensDigit = 3'h0;
						if (curTime.hoursTensDigit == 2'h2 &&
							curTime.hoursUnitsDigit == 4'h3) begin
							incTime.hoursTensDigit = 2'h0; // R01
							incTime.hoursUnitsDigit = 4'h0;
						end else if (curTime.hoursUnitsDigit == 4'h9) begin
							incTime.hoursUnitsDigit = 4'h0;
							incTime.hoursTensDigit = curTime.hoursTensDigit + 2'h1; // R01
						end else begin
							incTime.hoursUnitsDigit = curTime.hoursUnitsDigit + 4'h1;
						end
					end
				end
			end
		end
	end

	// BCD calendar increment on day rollover
	always_comb begin
		incDate = curDate;
		incDate.reserved23 = 3'h0;
		incDate.reserved15 = 2'h0;
		incDate.reserved7 = 5'h0;
		incDate.weekdayDigit = (curDate.weekdayDigit >= 3'h6) ? 3'h0 :
			curDate.weekdayDigit + 3'h1; // R07
		if (dayNum < lastDay) begin
			if (curDate.domUnitsDigit == 4'h9) begin
				incDate.domUnitsDigit = 4'h0;
				incDate.domTensDigit = curDate.domTensDigit + 2'h1; // R06
			end else begin
				incDate.domUnitsDigit = curDate.domUnitsDigit + 4'h1; // R06
			end
		end else begin
			incDate.domTensDigit = 2'h0;
			incDate.domUnitsDigit = 4'h1;
			if (monthNum >= 5'h0C) begin
				incDate.monthsTensDigit = 1'b0; // R05
				incDate.monthsUnitsDigit = 4'h1;
				if (curDate.yearsUnitsDigit == 4'h9) begin
					incDate.yearsUnitsDigit = 4'h0;
					incDate.yearsTensDigit = (curDate.yearsTensDigit == 4'h9) ? 4'h0 :
						curDate.yearsTensDigit + 4'h1; // R04
				end else begin
					incDate.yearsUnitsDigit = curDate.yearsUnitsDigit + 4'h1; // R04
				end
			end else if (curDate.monthsUnitsDigit == 4'h9) begin
				incDate.monthsTensDigit = 1'b1; // R05
				incDate.monthsUnitsDigit = 4'h0;
			end else begin
				incDate.monthsUnitsDigit = curDate.monthsUnitsDigit + 4'h1; // R05
			end
		end
	end

	// Software write wins over the counter; unused bits are never stored
	assign next_time = wrTime ? (regReq.wdata & `RTC_TIME_MASK) :
		tickPulse ? 32'(incTime) : timeReg; // R09
	assign next_date = wrDate ? (regReq.wdata & `RTC_DATE_MASK) :
		dayCarry ? 32'(incDate) : dateReg; // R09
	assign next_rdata = !regReq.rd ? 32'h0 :
		hitTime ? (timeReg & `RTC_TIME_MASK) :
		hitDate ? (dateReg & `RTC_DATE_MASK) :
		hitCtrl ? ctrlRead : 32'h0; // R09

	always_ff @(posedge clk_sys or negedge rstSync) begin
		if (!rstSync) begin
			timeReg <= `RTC_TIME_RESET;
			dateReg <= `RTC_DATE_RESET;
			wrenReg <= 1'b0;
			regRdata <= 32'h0;
		end else if (clkEn) begin
			timeReg <= next_time; // R10
			dateReg <= next_date; // R10
			regRdata <= next_rdata;
			if (wrCtrl) begin
				wrenReg <= regReq.wdata[`RTC_CTRL_WREN_BIT]; // R08
			end
		end
	end

	assign clockWriteEnable = wrenReg;

	property p_write_blocked;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && regReq.wr && hitTime && !wrenReg && !tickPulse) |=> $stable(timeReg);
	endproperty
	a_write_blocked: assert property (p_write_blocked) else $error("time written while locked"); // R08

	property p_write_taken;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && regReq.wr && hitDate && wrenReg) |=>
			dateReg == ($past(regReq.wdata) & `RTC_DATE_MASK);
	endproperty
	a_write_taken: assert property (p_write_taken) else $error("date write not stored"); // R08

	property p_time_unused_zero;
		@(posedge clk_sys) disable iff (!rstSync)
		(timeReg & ~`RTC_TIME_MASK) == 32'h0;
	endproperty
	a_time_unused_zero: assert property (p_time_unused_zero) else $error("time unused bit set"); // R09

	property p_date_unused_zero;
		@(posedge clk_sys) disable iff (!rstSync)
		(dateReg & ~`RTC_DATE_MASK) == 32'h0;
	endproperty
	a_date_unused_zero: assert property (p_date_unused_zero) else $error("date unused bit set"); // R09

	sequence s_tick_no_write;
		clkEn && tickPulse && !wrTime && curTime.secondsUnitsDigit < 4'h9;
	endsequence

	property p_seconds_step;
		@(posedge clk_sys) disable iff (!rstSync)
		s_tick_no_write |=> curTime.secondsUnitsDigit == $past(curTime.secondsUnitsDigit) + 4'h1;
	endproperty
	a_seconds_step: assert property (p_seconds_step) else $error("seconds did not step"); // R10

	property p_hold_between_ticks;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && !tickPulse && !wrTime) |=> $stable(timeReg);
	endproperty
	a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("time moved"); // R10

	property p_hours_range;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && tickPulse && !wrTime && curTime.hoursTensDigit == 2'h2 &&
			curTime.hoursUnitsDigit == 4'h3 && incTime.minutesTensDigit == 3'h0 &&
			curTime.minutesTensDigit == 3'h5 && curTime.minutesUnitsDigit == 4'h9 &&
			curTime.secondsTensDigit == 3'h5 && curTime.secondsUnitsDigit == 4'h9)
			|=> curTime.hoursTensDigit == 2'h0 && curTime.hoursUnitsDigit == 4'h0;
	endproperty
	a_hours_range: assert property (p_hours_range) else $error("hour failed to wrap"); // R01

	property p_weekday_wrap;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && dayCarry && !wrDate && curDate.weekdayDigit == 3'h6)
			|=> curDate.weekdayDigit == 3'h0;
	endproperty
	a_weekday_wrap: assert property (p_weekday_wrap) else $error("weekday failed to wrap"); // R07

	property p_read_one_cycle;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && regReq.rd && hitCtrl) |=> regRdata == {28'h0, $past(wrenReg), 3'h0};
	endproperty
	a_read_one_cycle: assert property (p_read_one_cycle) else $error("control read wrong"); // R08

	sequence s_time_step;
		clkEn && tickPulse && !wrTime;
	endsequence

	sequence s_day_rollover;
		clkEn && dayCarry && !wrDate;
	endsequence

	property p_time_taken;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && wrTime) |=> timeReg == ($past(regReq.wdata) & `RTC_TIME_MASK);
	endproperty
	a_time_taken: assert property (p_time_taken) else $error("time write not stored"); // R08

	property p_date_locked;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && regReq.wr && hitDate && !wrenReg && !dayCarry) |=> $stable(dateReg);
	endproperty
	a_date_locked: assert property (p_date_locked) else $error("date written while locked"); // R08

	property p_ctrl_taken;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && wrCtrl) |=> clockWriteEnable == $past(regReq.wdata[`RTC_CTRL_WREN_BIT]);
	endproperty
	a_ctrl_taken: assert property (p_ctrl_taken) else $error("enable bit not stored"); // R08

	property p_seconds_ok;
		@(posedge clk_sys) disable iff (!rstSync)
		s_time_step ##0 secondsOk |=> secondsOk;
	endproperty
	a_seconds_ok: assert property (p_seconds_ok) else $error("seconds out of range"); // R03

	property p_minutes_ok;
		@(posedge clk_sys) disable iff (!rstSync)
		s_time_step ##0 minutesOk |=> minutesOk;
	endproperty
	a_minutes_ok: assert property (p_minutes_ok) else $error("minutes out of range"); // R02

	property p_hours_ok;
		@(posedge clk_sys) disable iff (!rstSync)
		s_time_step ##0 hoursOk |=> hoursOk;
	endproperty
	a_hours_ok: assert property (p_hours_ok) else $error("hours out of range"); // R01

	property p_dom_ok;
		@(posedge clk_sys) disable iff (!rstSync)
		s_day_rollover ##0 dateOk |=> dayOk;
	endproperty
	a_dom_ok: assert property (p_dom_ok) else $error("day of month out of range"); // R06

	property p_month_ok;
		@(posedge clk_sys) disable iff (!rstSync)
		s_day_rollover ##0 dateOk |=> monthOk;
	endproperty
	a_month_ok: assert property (p_month_ok) else $error("month out of range"); // R05

	property p_year_ok;
		@(posedge clk_sys) disable iff (!rstSync)
		s_day_rollover ##0 dateOk |=> yearOk;
	endproperty
	a_year_ok: assert property (p_year_ok) else $error("year out of range"); // R04

	property p_weekday_ok;
		@(posedge clk_sys) disable iff (!rstSync)
		s_day_rollover ##0 dateOk |=> weekdayOk;
	endproperty
	a_weekday_ok: assert property (p_weekday_ok) else $error("weekday out of range"); // R07

	property p_date_hold;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && !dayCarry && !wrDate) |=> $stable(dateReg);
	endproperty
	a_date_hold: assert property (p_date_hold) else $error("date moved"); // R10

	property p_freeze;
		@(posedge clk_sys) disable iff (!rstSync)
		!clkEn |=> $stable(timeReg) && $stable(dateReg) && $stable(regRdata) && $stable(tickCnt);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled"); // R10

	property p_read_idle;
		@(posedge clk_sys) disable iff (!rstSync)
		(clkEn && !regReq.rd) |=> regRdata == 32'h0;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data not cleared"); // R09

endmodule

//--- dv/rtc_time_date_registers_tb.sv
// Self-checking bench for the time and date register block
`timescale 1ns/100ps
`include "rtc_time_date_defines.svh"

module rtc_time_date_registers_tb;
	import rtc_time_date_pkg::*;
	localparam int unsigned TICK = 5000;
	logic                   clk_sys;
	logic                   reset_n;
	logic                   clkEn;
	reg_req_s               regReq;
	logic [31:0]            regRdata;
	logic                   clockWriteEnable;
	logic                   wenSeen;
	logic [31:0]            rdVal;
	int                     failures;
	int                     compares;
	int                     n;

	rtc_time_date_registers #(.TICK_CYCLES(TICK)) DUT (
		.clk_sys          (clk_sys),
		.reset_n          (reset_n),
		.clkEn            (clkEn),
		.regReq           (regReq),
		.regRdata         (regRdata),
		.clockWriteEnable (clockWriteEnable)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One bus cycle, entered and left at a rising edge
	task automatic reg_write(input logic [`RTC_ADDR_W-1:0] a, input logic [31:0] d);
		regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
	endtask

	task automatic check_reg(input logic [`RTC_ADDR_W-1:0] a, input logic [31:0] exp);
		regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
		#1;
		rdVal = regRdata;
		wenSeen = clockWriteEnable;
		@(posedge clk_sys);
		check(rdVal, exp, "register read");
	endtask

	// Reads time every cycle until it changes; optional clock-enable pause
	task automatic wait_tick(input int pauseAt, output int cnt);
		logic [31:0] first;
		@(posedge clk_sys);
		regReq <= '{addr: `RTC_OFS_TIME, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		#1;
		first = regRdata;
		cnt = 0;
		do begin
			@(posedge clk_sys);
			if (cnt == pauseAt) clkEn <= 1'b0;
			if (cnt == pauseAt + 100) clkEn <= 1'b1;
			#1;
			cnt++;
		end while (regRdata === first && cnt < 3 * TICK);
		if (cnt >= 3 * TICK) begin
			failures++;
			$display("mismatch at %0t: time never advanced", $time);
			give_verdict();
		end
	endtask

	// Last second of a day, then the calendar after the tick
	task automatic midnight(input logic [31:0] d, input logic [31:0] exp);
		int cnt;
		reg_write(`RTC_OFS_TIME, 32'h2359_5900);
		reg_write(`RTC_OFS_DATE, d);
		check_reg(`RTC_OFS_DATE, d);
		wait_tick(-1, cnt);
		check(regRdata, 32'h0000_0000, "time at midnight");
		@(posedge clk_sys);
		check_reg(`RTC_OFS_DATE, exp);
	endtask

	initial begin
		reset_n = 1'b0;
		clkEn = 1'b1;
		regReq = '0;
		failures = 0;
		compares = 0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check_reg(`RTC_OFS_TIME, `RTC_TIME_RESET);
		check_reg(`RTC_OFS_DATE, `RTC_DATE_RESET);
		check({31'h0, wenSeen}, 32'h0, "write enable after reset");
		// Writes refused while the enable bit is clear
		reg_write(`RTC_OFS_TIME, 32'h1234_5600);
		reg_write(`RTC_OFS_DATE, 32'h2107_1503);
		check_reg(`RTC_OFS_TIME, `RTC_TIME_RESET);
		check_reg(`RTC_OFS_DATE, `RTC_DATE_RESET);
		reg_write(`RTC_OFS_CTRL, 32'hFFFF_FFFF);
		check_reg(`RTC_OFS_CTRL, 32'h0000_0008);
		check({31'h0, wenSeen}, 32'h1, "write enable set");
		// Unused bits read zero
		reg_write(`RTC_OFS_TIME, 32'hFFFF_FFFF);
		reg_write(`RTC_OFS_DATE, 32'hFFFF_FFFF);
		check_reg(`RTC_OFS_TIME, 32'h3F7F_7F00);
		check_reg(`RTC_OFS_DATE, 32'hFF1F_3F07);
		check_reg(4'hC, 32'h0);
		#1;
		check(regRdata, 32'h0, "idle read data");
		@(posedge clk_sys);
		// Field placement at the top of every range
		reg_write(`RTC_OFS_TIME, 32'h2359_5900);
		reg_write(`RTC_OFS_DATE, 32'h9912_3106);
		check_reg(`RTC_OFS_TIME, 32'h2359_5900);
		check_reg(`RTC_OFS_DATE, 32'h9912_3106);
		// Full rollover of time and calendar
		wait_tick(-1, n);
		check(regRdata, 32'h0000_0000, "midnight rollover");
		@(posedge clk_sys);
		check_reg(`RTC_OFS_DATE, 32'h0001_0100);
		wait_tick(-1, n);
		wait_tick(-1, n);
		check(n, TICK - 2, "tick interval");
		check(regRdata, 32'h0000_0200, "second count");
		wait_tick(10, n);
		check(n, TICK + 98, "tick interval with pause");
		@(posedge clk_sys);
		// Seconds carry into tens
		reg_write(`RTC_OFS_TIME, 32'h1234_0900);
		check_reg(`RTC_OFS_TIME, 32'h1234_0900);
		wait_tick(-1, n);
		check(regRdata, 32'h1234_1000, "seconds carry");
		@(posedge clk_sys);
		// Month ends, leap and common February
		midnight(32'h2402_2803, 32'h2402_2904);
		midnight(32'h2302_2805, 32'h2303_0106);
		midnight(32'h2104_3006, 32'h2105_0100);
		midnight(32'h2109_3002, 32'h2110_0103);
		// Reset in mid-run
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		check({31'h0, clockWriteEnable}, 32'h0, "write enable in reset");
		check(regRdata, 32'h0, "read data in reset");
		@(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check_reg(`RTC_OFS_TIME, `RTC_TIME_RESET);
		check_reg(`RTC_OFS_DATE, `RTC_DATE_RESET);
		check_reg(`RTC_OFS_CTRL, 32'h0);
		give_verdict();
	end
endmodule
